//--- common/bqs_map.vh
// Purpose: constants for the burst-of-four static memory port
// Assumes: 36-bit variant, 2M words
// Notes: change the width and address constants together for the 18-bit variant
`ifndef BQS_MAP_VH
`define BQS_MAP_VH
`define BQS_DATA_W 36
`define BQS_ADDR_W 21
`define BQS_LANES 4
`define BQS_BURST 4
`define BQS_DEPTH_WORDS 64
`define BQS_MEM_AW 6
`define BQS_RD_LAT_HALVES 3
`define BQS_RD_LAT_BYPASS_HALVES 2
`endif

//--- rtl/bqs_port.v
// Purpose: burst-of-four double-rate static memory port, device side
// Assumes: all link clocks and pins are sampled by clk_i, well above link rate
// Notes: the storage array is a reduced model depth; the address is wrapped into it
// Functional notes
// - Read and write slots interleave on alternating rising edges of the positive input clock; here any rise takes both.
// - Address, read select and write select are sampled on positive input clock rise.
// - Beats one and three of write data and strobes taken on positive clock rise.
// - Beats two and four of write data and strobes taken on negative clock rise.
// - Byte strobes may change every beat, gating each byte lane per beat.
// - A write spans two and a half input clock cycles from command to last beat.
// - A read spans two full clock cycles to deliver its burst.
// - Read beats one and three follow negative output clock; first 1.5 cycles after command.
// - Read beats two and four follow the positive output clock rises.
// - With both output clocks held high, read data is timed from the input clocks.
// - Every read and write moves exactly four beats; burst length is fixed.
// - Separate input and output data ports allow concurrent read and write.
// - Complementary echo clocks transition together with read data.
// - Data path is 36 bits by 2M words or 18 bits by 4M words.
// - With the loop bypass held low, read latency is 1.0 cycle instead of 1.5.
// - Echo clocks run continuously, also while read data is not driven.
// - Address is ignored on cycles with neither read nor write selected.
`timescale 1ns/1ps
`default_nettype none
`include "bqs_map.vh"

module bqs_port (
	input wire clk_i,
	input wire rst_i,
	input wire in_clk_pos_i,
	input wire in_clk_neg_i,
	input wire out_clk_pos_i,
	input wire out_clk_neg_i,
	input wire dll_on_i,
	input wire read_sel_n_i,
	input wire write_sel_n_i,
	input wire [`BQS_ADDR_W-1:0] word_address_i,
	input wire [`BQS_LANES-1:0] byte_lane_write_n_i,
	input wire [`BQS_DATA_W-1:0] wr_data_i,
	output reg [`BQS_DATA_W-1:0] rd_data_o,
	output reg rd_data_oe_o,
	output reg echo_timing_pos_o,
	output reg echo_timing_neg_o
);

	localparam LW = `BQS_DATA_W / `BQS_LANES; // Nine-bit lanes of the 36-bit variant
	localparam ST_IDLE = 2'd0;
	localparam ST_BUSY = 2'd1;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// A change counts when stages two and three agree; stage one is read by stage two only
	wire [5:0] raw_in = {in_clk_pos_i, in_clk_neg_i, out_clk_pos_i, out_clk_neg_i, dll_on_i, 1'b0};
	reg [5:0] sync1;
	reg [5:0] sync2;
	reg [5:0] sync3;
	reg [5:0] clean;
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_sync
			always @(posedge clk_i) begin
				if (rst_i) begin
					sync1[g] <= 1'b0;
					sync2[g] <= 1'b0;
					sync3[g] <= 1'b0;
					clean[g] <= 1'b0;
				end else begin
					sync1[g] <= raw_in[g];
					sync2[g] <= sync1[g];
					sync3[g] <= sync2[g];
					if (sync2[g] == sync3[g]) begin
						clean[g] <= sync3[g];
					end
				end
			end
		end
	endgenerate

	// Data pins are delayed to line up with the synchronised clocks
	reg [`BQS_ADDR_W-1:0] addr_d1, addr_d2, addr_d3;
	reg [`BQS_LANES-1:0] bw_d1, bw_d2, bw_d3;
	reg [`BQS_DATA_W-1:0] din_d1, din_d2, din_d3;
	reg rsel_d1, rsel_d2, rsel_d3;
	reg wsel_d1, wsel_d2, wsel_d3;
	always @(posedge clk_i) begin
		addr_d1 <= word_address_i;
		addr_d2 <= addr_d1;
		addr_d3 <= addr_d2;
		bw_d1 <= byte_lane_write_n_i;
		bw_d2 <= bw_d1;
		bw_d3 <= bw_d2;
		din_d1 <= wr_data_i;
		din_d2 <= din_d1;
		din_d3 <= din_d2;
		rsel_d1 <= read_sel_n_i;
		rsel_d2 <= rsel_d1;
		rsel_d3 <= rsel_d2;
		wsel_d1 <= write_sel_n_i;
		wsel_d2 <= wsel_d1;
		wsel_d3 <= wsel_d2;
	end

	reg kp_q, kn_q, cp_q, cn_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			kp_q <= 1'b0;
			kn_q <= 1'b0;
			cp_q <= 1'b0;
			cn_q <= 1'b0;
		end else begin
			kp_q <= clean[5];
			kn_q <= clean[4];
			cp_q <= clean[3];
			cn_q <= clean[2];
		end
	end
	wire k_rise = clean[5] & ~kp_q;
	wire kn_rise = clean[4] & ~kn_q;
	wire c_rise = clean[3] & ~cp_q;
	wire cn_rise = clean[2] & ~cn_q;
	wire dll_on = clean[1];
	// Output clocks parked high select the input clock pair instead
	wire use_k = clean[3] & clean[2] & ~c_rise & ~cn_rise;
	wire ot_pos_rise = use_k ? k_rise : c_rise;
	wire ot_neg_rise = use_k ? kn_rise : cn_rise;

	// ****************************************
	// Write path
	// ****************************************
	// Four beats are fixed; no burst length control exists
	reg [`BQS_DATA_W-1:0] mem [0:`BQS_DEPTH_WORDS-1];
	reg [1:0] wr_state;
	reg [2:0] wr_beat;
	reg wr_pending;
	reg [`BQS_MEM_AW-1:0] wr_addr;
	reg [`BQS_MEM_AW-1:0] pend_addr;

	function [`BQS_DATA_W-1:0] lane_merge;
		input [`BQS_DATA_W-1:0] old_w;
		input [`BQS_DATA_W-1:0] new_w;
		input [`BQS_LANES-1:0] bw_n;
		integer i;
		begin
			lane_merge = old_w;
			for (i = 0; i < `BQS_LANES; i = i + 1) begin
				if (!bw_n[i]) begin
					lane_merge[i*LW +: LW] = new_w[i*LW +: LW];
				end
			end
		end
	endfunction

	// Two-entry buffer between beat capture and the array; array stalls on read-write collision
	reg [`BQS_DATA_W-1:0] fb_data [0:1];
	reg [`BQS_LANES-1:0] fb_bw [0:1];
	reg [`BQS_MEM_AW-1:0] fb_addr [0:1];
	reg [1:0] fb_cnt;
	reg fb_wp, fb_rp;
	wire fb_in_ready = (fb_cnt != 2'd2);
	wire beat_take = (wr_state == ST_BUSY) && (wr_beat[0] ? kn_rise : k_rise);
	wire fb_in_valid = beat_take;
	wire fb_out_valid = (fb_cnt != 2'd0);
	wire arr_rd_busy;
	wire fb_out_ready = ~arr_rd_busy;

	// Command slot toggles on each rise but gates no command: one rise can take both a write and a read
	reg slot;
	always @(posedge clk_i) begin
		if (rst_i) begin
			slot <= 1'b0;
		end else if (k_rise) begin
			slot <= ~slot;
		end
	end

	wire wr_cmd = k_rise && !wsel_d3;
	wire rd_cmd = k_rise && !rsel_d3;

	always @(posedge clk_i) begin
		if (rst_i) begin
			wr_state <= ST_IDLE;
			wr_beat <= 3'd0;
			wr_pending <= 1'b0;
			wr_addr <= {`BQS_MEM_AW{1'b0}};
			pend_addr <= {`BQS_MEM_AW{1'b0}};
		end else begin
			case (wr_state)
				ST_IDLE: begin
					if (wr_cmd) begin
						// Address captured only when selected
						wr_addr <= addr_d3[`BQS_MEM_AW-1:0];
						wr_beat <= 3'd0;
						wr_state <= ST_BUSY;
					end
				end
				ST_BUSY: begin
					// The first rise after the command takes beat one: the late-write gap
					if (beat_take) begin
						// A write on the third-beat rise is the next command, one per two cycles
						if (wr_beat == 3'd2 && wr_cmd) begin
							wr_pending <= 1'b1;
							pend_addr <= addr_d3[`BQS_MEM_AW-1:0];
						end
						if (wr_beat == 3'd3) begin
							// Command to last beat spans two and a half cycles
							if (wr_pending) begin
								wr_addr <= pend_addr;
								wr_pending <= 1'b0;
								wr_beat <= 3'd0;
							end else begin
								wr_state <= ST_IDLE;
								wr_beat <= 3'd0;
							end
						end else begin
							wr_beat <= wr_beat + 3'd1;
						end
					end
				end
				default: wr_state <= ST_IDLE;
			endcase
		end
	end

	// Words of the burst are the four consecutive words from the base
	wire [`BQS_MEM_AW-1:0] beat_addr = wr_addr + {{(`BQS_MEM_AW-3){1'b0}}, wr_beat};
	wire fb_push = fb_in_valid & fb_in_ready;
	wire fb_pop = fb_out_valid & fb_out_ready;
	always @(posedge clk_i) begin
		if (rst_i) begin
			fb_cnt <= 2'd0;
			fb_wp <= 1'b0;
			fb_rp <= 1'b0;
		end else begin
			if (fb_push) begin
				fb_data[fb_wp] <= din_d3;
				fb_bw[fb_wp] <= bw_d3;
				fb_addr[fb_wp] <= beat_addr;
				fb_wp <= ~fb_wp;
			end
			if (fb_pop) begin
				mem[fb_addr[fb_rp]] <= lane_merge(mem[fb_addr[fb_rp]], fb_data[fb_rp], fb_bw[fb_rp]);
				fb_rp <= ~fb_rp;
			end
			fb_cnt <= fb_cnt + {1'b0, fb_push} - {1'b0, fb_pop};
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// Own output port, independent of the write path
	reg [1:0] rd_state;
	reg [2:0] rd_lead;
	reg [2:0] rd_beat;
	reg rd_pending;
	reg [`BQS_MEM_AW-1:0] rd_addr;
	reg [`BQS_MEM_AW-1:0] rd_pend_addr;
	reg [`BQS_DATA_W-1:0] rd_word;
	wire [2:0] lat_halves = dll_on ? 3'd`BQS_RD_LAT_HALVES : 3'd`BQS_RD_LAT_BYPASS_HALVES;
	wire half_edge = ot_pos_rise | ot_neg_rise;
	// Array is read every clk_i cycle; each beat takes the word read one cycle before its half-edge
	assign arr_rd_busy = (rd_state == ST_BUSY) && half_edge;
	wire [`BQS_MEM_AW-1:0] rd_beat_addr = rd_addr + {{(`BQS_MEM_AW-3){1'b0}}, rd_beat};

	always @(posedge clk_i) begin
		rd_word <= mem[rd_beat_addr];
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			rd_state <= ST_IDLE;
			rd_lead <= 3'd0;
			rd_beat <= 3'd0;
			rd_pending <= 1'b0;
			rd_addr <= {`BQS_MEM_AW{1'b0}};
			rd_pend_addr <= {`BQS_MEM_AW{1'b0}};
			rd_data_o <= {`BQS_DATA_W{1'b0}};
			rd_data_oe_o <= 1'b0;
			echo_timing_pos_o <= 1'b0;
			echo_timing_neg_o <= 1'b1;
		end else begin
			// Echo pair follows the timing clocks always, driven or not
			if (ot_pos_rise) begin
				echo_timing_pos_o <= 1'b1;
				echo_timing_neg_o <= 1'b0;
			end else if (ot_neg_rise) begin
				echo_timing_pos_o <= 1'b0;
				echo_timing_neg_o <= 1'b1;
			end
			if (rd_cmd && rd_state == ST_BUSY) begin
				rd_pending <= 1'b1;
				rd_pend_addr <= addr_d3[`BQS_MEM_AW-1:0];
			end
			case (rd_state)
				ST_IDLE: begin
					if (rd_cmd) begin
						rd_addr <= addr_d3[`BQS_MEM_AW-1:0];
						rd_lead <= 3'd0;
						rd_beat <= 3'd0;
						rd_state <= ST_BUSY;
					end
					if (half_edge) begin
						rd_data_oe_o <= 1'b0;
					end
				end
				ST_BUSY: begin
					if (half_edge) begin
						if (rd_lead + 3'd1 < lat_halves) begin
							rd_lead <= rd_lead + 3'd1;
							// Output idles while the latency runs down
							rd_data_oe_o <= 1'b0;
						end else begin
							// Beats 1,3 on negative rises, 2,4 on positive with the DLL on; swapped with it off
							rd_data_o <= rd_word;
							rd_data_oe_o <= 1'b1;
							if (rd_beat == 3'd3) begin
								// Four beats over two cycles
								if (rd_pending || rd_cmd) begin
									rd_addr <= rd_pending ? rd_pend_addr : addr_d3[`BQS_MEM_AW-1:0];
									rd_pending <= 1'b0;
									rd_beat <= 3'd0;
									if (!rd_pending) begin
										// A command on the last beat's rise still waits its full latency
										rd_lead <= 3'd0;
									end
								end else begin
									rd_state <= ST_IDLE;
								end
							end else begin
								rd_beat <= rd_beat + 3'd1;
							end
						end
					end
				end
				default: rd_state <= ST_IDLE;
			endcase
		end
	end

endmodule // bqs_port
`default_nettype wire

//--- bench/bqs_port_monitor.sv
// Purpose: port checker for bqs_port
// Assumes: link clock of eight clk_i cycles
// Notes: windows allow for the pin sync delay
`timescale 1ns/1ps
`default_nettype none
`include "bqs_map.vh"
module bqs_mon (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_clk_pos_i,
	input wire logic dll_on_i,
	input wire logic read_sel_n_i,
	input wire logic [`BQS_DATA_W-1:0] rd_data_o,
	input wire logic rd_data_oe_o,
	input wire logic echo_timing_pos_o,
	input wire logic echo_timing_neg_o
);
// ****
// Checks
// ****
default clocking @(posedge clk_i);
endclocking
default disable iff (rst_i);
logic kd;
logic rc;
logic [7:0] run;
logic [3:0] ec;
// Counters keep the repeats short
always_ff @(posedge clk_i) begin
	kd <= in_clk_pos_i;
	run <= (rst_i || !rd_data_oe_o) ? 8'h00 : run + 8'h01;
	ec <= (rst_i || $changed(echo_timing_pos_o)) ? 4'h0 : ec + 4'h1;
end
assign rc = in_clk_pos_i && !kd && !read_sel_n_i;
read_lat_a:
	assert property (rc && dll_on_i |-> ##[15:19] rd_data_oe_o) else $error("late read");
read_early_a:
	assert property (rc && dll_on_i |-> ##6 (!$rose(rd_data_oe_o)) [*8]) else $error("early read");
bypass_lat_a:
	assert property (rc && !dll_on_i |-> ##[10:14] $rose(rd_data_oe_o)) else $error("bypass latency");
echo_pair_a:
	assert property (echo_timing_pos_o != echo_timing_neg_o) else $error("echo pair");
echo_run_a:
	assert property (ec < 4'hc) else $error("echo stopped");
burst_len_a:
	assert property ($fell(rd_data_oe_o) |-> run == 8'h10) else $error("burst length");
data_hold_a:
	assert property (rd_data_oe_o && !$changed(echo_timing_pos_o) |=> $stable(rd_data_o) || !rd_data_oe_o
		|| $changed(echo_timing_pos_o)) else $error("data off echo");
oe_edge_a:
	assert property ($changed(rd_data_oe_o) |-> $changed(echo_timing_pos_o)) else $error("enable off echo");
endmodule // bqs_mon
`default_nettype wire

//--- bench/bqs_ctl_model.sv
// Purpose: controller model for the bqs_port link pins
// Assumes: clk_i at eight times the link rate
// Notes: pins move two clk_i cycles before each sampling edge
`timescale 1ns/1ps
`default_nettype none
module bqs_ctl (
	input wire logic clk_i,
	input wire logic tie_i,
	output var logic kp_o,
	output var logic kn_o,
	output var logic cp_o,
	output var logic cn_o,
	output var logic rs_n_o,
	output var logic ws_n_o,
	output var logic [20:0] adr_o,
	output var logic [3:0] bw_n_o,
	output var logic [35:0] wd_o
);
// ****
// Link pins
// ****
logic [2:0] ph = 3'h0;
always @(posedge clk_i) ph <= ph + 3'h1;
// Input clocks run free; output clocks copy them unless tie_i parks them high, when the echo clocks follow the input clocks
assign kp_o = !ph[2];
assign kn_o = ph[2];
assign cp_o = tie_i | !ph[2];
assign cn_o = tie_i | ph[2];
initial begin
	rs_n_o = 1'b1;
	ws_n_o = 1'b1;
	adr_o = 21'h0;
	bw_n_o = 4'hf;
	wd_o = 36'h0;
end
task automatic kcycle(input logic rd, input logic wr, input logic [20:0] a,
	input logic [35:0] da, input logic [35:0] db, input logic [3:0] ba, input logic [3:0] bb);
	do @(posedge clk_i); while (ph != 3'h5);
	rs_n_o <= !rd;
	ws_n_o <= !wr;
	adr_o <= a;
	wd_o <= da;
	bw_n_o <= ba;
	do @(posedge clk_i); while (ph != 3'h1);
	adr_o <= ~a;
	wd_o <= db;
	bw_n_o <= bb;
endtask
endmodule // bqs_ctl
`default_nettype wire

//--- bench/testbench.sv
// Purpose: self-checking bench for bqs_port
// Assumes: 40 MHz clk_i, 200 ns link clock
// Notes: bases are kept aligned to four words
`timescale 1ns/1ps
`default_nettype none
module testbench;
// ****
// Bench
// ****
logic clk_i = 1'b0;
logic rst_i = 1'b1;
logic tie = 1'b0;
logic dll = 1'b1;
wire kp, kn, cp, cn, rs_n, ws_n, oe, ep, en;
wire [20:0] adr;
wire [3:0] bw;
wire [35:0] wd, rd;
logic [35:0] mem [0:63];
logic [35:0] exp_q [$];
logic [35:0] got_q [$];
logic pe, poe;
int bad_count = 0;
int total_checks = 0;
int i;
logic [20:0] ta [5] = '{21'h0, 21'h4, 21'h0, 21'h3c, 21'h1fff04};
logic [35:0] ts [5] = '{36'h123456789, 36'hfedcba987, 36'h05a5a5a5a, 36'hc0ffee123, 36'h333333333};
logic [15:0] tb [5] = '{16'h0, 16'h0, 16'h1e87, 16'h0, 16'hf0c3};
bqs_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .in_clk_pos_i(kp), .in_clk_neg_i(kn),
	.out_clk_pos_i(cp), .out_clk_neg_i(cn), .dll_on_i(dll), .read_sel_n_i(rs_n), .write_sel_n_i(ws_n),
	.word_address_i(adr), .byte_lane_write_n_i(bw), .wr_data_i(wd), .rd_data_o(rd),
	.rd_data_oe_o(oe), .echo_timing_pos_o(ep), .echo_timing_neg_o(en));
bqs_ctl u_ctl (.clk_i(clk_i), .tie_i(tie), .kp_o(kp), .kn_o(kn), .cp_o(cp), .cn_o(cn),
	.rs_n_o(rs_n), .ws_n_o(ws_n), .adr_o(adr), .bw_n_o(bw), .wd_o(wd));
initial forever #12.5 clk_i = ~clk_i;
// A new beat is taken on each echo edge while driven
always @(posedge clk_i) begin
	pe <= ep;
	poe <= oe;
	if (!rst_i && oe === 1'b1 && (poe !== 1'b1 || ep !== pe)) got_q.push_back(rd);
end
function automatic logic [35:0] wv(input logic [35:0] s, input int k);
	return s + 36'(k) * 36'h040100401;
endfunction
task automatic chk_w(input logic [35:0] g, input logic [35:0] e);
	total_checks++;
	if (g !== e) begin
		bad_count++;
		$display("[ERR] %0t got %h exp %h", $time, g, e);
	end
endtask
task automatic row(input logic [20:0] a, input logic [35:0] s, input logic [15:0] b, input logic r,
	input logic [20:0] ra);
	int k;
	int l;
	logic [35:0] w;
	for (k = 0; k < 4 && r; k++) exp_q.push_back(mem[(ra + k) & 63]);
	u_ctl.kcycle(1'b0, 1'b1, a, ~s, s, 4'hf, 4'hf);
	u_ctl.kcycle(r, 1'b0, ra, wv(s, 0), wv(s, 1), b[3:0], b[7:4]);
	u_ctl.kcycle(1'b0, 1'b0, ~a, wv(s, 2), wv(s, 3), b[11:8], b[15:12]);
	for (k = 0; k < 4; k++) begin
		w = wv(s, k);
		for (l = 0; l < 4; l++) if (!b[4 * k + l]) mem[(a + k) & 63][9 * l +: 9] = w[9 * l +: 9];
	end
endtask
// Idle cycles around the read keep bursts apart
task automatic rd1(input logic [20:0] a);
	int k;
	for (k = 0; k < 4; k++) exp_q.push_back(mem[(a + k) & 63]);
	for (k = 0; k < 5; k++) u_ctl.kcycle(k == 1, 1'b0, k == 1 ? a : 21'h15555, 36'h0, 36'hfffffffff,
		4'hf, 4'hf);
endtask
task automatic summarize();
	$display("checks %0d errors %0d", total_checks, bad_count);
	if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
	else $display("TEST FAILED");
	$finish;
endtask
initial begin
	repeat (20) @(posedge clk_i);
	#1 chk_w({33'h0, oe, ep, en}, 36'h1);
	@(posedge clk_i);
	rst_i <= 1'b0;
	repeat (8) @(posedge clk_i);
	for (i = 0; i < 5; i++) row(ta[i], ts[i], tb[i], i > 0, i > 0 ? ta[i - 1] : 21'h0);
	rd1(21'h1fff04);
	dll <= 1'b0;
	rd1(21'h3c);
	dll <= 1'b1;
	rst_i <= 1'b1;
	repeat (3) @(posedge clk_i);
	#1 chk_w({33'h0, oe, ep, en}, 36'h1);
	@(posedge clk_i);
	rst_i <= 1'b0;
	repeat (8) @(posedge clk_i);
	row(21'h8, 36'h9abcdef01, 16'h0, 1'b0, 21'h0);
	tie <= 1'b1;
	rd1(21'h8);
	tie <= 1'b0;
	repeat (40) @(posedge clk_i);
	chk_w(36'(got_q.size()), 36'(exp_q.size()));
	foreach (exp_q[j]) chk_w(got_q[j], exp_q[j]);
	summarize();
end
initial begin
	#100000;
	bad_count++;
	summarize();
end
endmodule // testbench
bind bqs_port bqs_mon u_mon (.clk_i(clk_i), .rst_i(rst_i), .in_clk_pos_i(in_clk_pos_i),
	.dll_on_i(dll_on_i), .read_sel_n_i(read_sel_n_i), .rd_data_o(rd_data_o), .rd_data_oe_o(rd_data_oe_o),
	.echo_timing_pos_o(echo_timing_pos_o), .echo_timing_neg_o(echo_timing_neg_o));
`default_nettype wire
